// ---- hics_config_slave.sv ----
// Overview of operation
// - ratio select held in tracking_setup bits 3:0
// - ratio codes decode to percent or impedance matching
// - codes 8,9 register only; straps limited per package
// - sampling timing held in tracking_setup bits 6:4
// - timing codes give duration and period; 0-3 register-only
// - overdischarge code X, 0.05625 V steps from 0.50625
// - overdischarge below 2.8 V is forced to 2.8
// - overcharge code Y, 0.05625 V steps from 1.2375
// - threshold strap picks fixed overcharge/overdischarge pair
// - serial port works up to 1 MHz clock
// - all bytes shifted most significant bit first
// - slave address 0x40/0x41 from strap, else 0x41
// - direction bit 1 means write, 0 read
// - acknowledge matching address by pulling data low
// - write: address, pointer, data, each acknowledged
// - further write bytes go to next pointer
// - read: pointer write, repeated start, read address
// - master ack fetches the next register
// - control select bit makes registers override straps
// - straps sampled at start, every 2 s / 1 s
`timescale 1ns/1ps
`default_nettype none
`include "hics_consts.svh"

module hics_config_slave #(
    parameter bit SMALL_PKG = 1'b0,
    parameter bit DIR_WRITE_VALUE = 1'b1,
    parameter int unsigned STRAP_PERIOD_CYCLES =
        `HICS_STRAP_PERIOD_MS * `HICS_CLK_KHZ,
    parameter int unsigned CHG_PERIOD_CYCLES =
        `HICS_CHG_PERIOD_MS * `HICS_CLK_KHZ
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic [2:0] ratio_strap_in,
    input wire logic [1:0] timing_strap_in,
    input wire logic [2:0] threshold_strap_in,
    input wire logic addr_strap_in,
    input wire logic charge_disable_strap_in,
    output logic [3:0] ratio_code_out,
    output logic [6:0] ratio_pct_out,
    output logic const_imp_out,
    output logic [2:0] timing_code_out,
    output logic [8:0] samp_dur_ms_out,
    output logic [14:0] samp_per_ms_out,
    output logic [14:0] ovdis_qmv_out,
    output logic [14:0] ovch_qmv_out,
    output logic charge_disable_out,
    output logic port_ready_out
);

    localparam logic [69:0] RATIO_PCT_TBL = `HICS_RATIO_PCT_TBL;
    localparam logic [71:0] DUR_MS_TBL = `HICS_DUR_MS_TBL;
    localparam logic [119:0] PER_MS_TBL = `HICS_PER_MS_TBL;
    localparam logic [119:0] STRAP_OVCH_TBL = `HICS_STRAP_OVCH_TBL;
    localparam logic [119:0] STRAP_OVDIS_TBL = `HICS_STRAP_OVDIS_TBL;
    localparam logic [31:0] STRAP_LAST = 32'(STRAP_PERIOD_CYCLES - 1);
    localparam logic [31:0] CHG_LAST = 32'(CHG_PERIOD_CYCLES - 1);

    // ---------------- system clock domain ----------------
    logic [1:0] scl_sync_r;
    logic [1:0] sda_sync_r;
    logic scl_d_r;
    logic sda_d_r;
    logic [9:0] strap_s1_r;
    logic [9:0] strap_s2_r;
    logic frame_rst_r;
    logic [1:0] wr_tgl_sync_r;
    logic wr_tgl_d_r;
    logic [6:0] tracking_r;
    logic [5:0] ovdis_r;
    logic [5:0] ovch_r;
    logic use_regs_r;
    logic [1:0] first_r;
    logic [31:0] strap_cnt_r;
    logic [31:0] chg_cnt_r;
    logic [2:0] ratio_smp_r;
    logic [1:0] timing_smp_r;
    logic [2:0] thr_smp_r;
    logic addr_smp_r;
    logic chg_smp_r;

    // ---------------- link clock domain ----------------
    hics_pkg::hics_lk_state_t state_r;
    hics_pkg::hics_lk_state_t state_nxt;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic [7:0] tx_r;
    logic ack_r;
    logic rd_first_r;
    logic [7:0] ptr_r;
    logic [7:0] wr_addr_lk_r;
    logic [7:0] wr_data_lk_r;
    logic wr_tgl_r;
    logic [1:0] addr_lk_r;
    logic sda_oe_r;

    // start and stop seen on the synchronised bus lines
    wire start_w = scl_sync_r[1] & scl_d_r & sda_d_r & ~sda_sync_r[1];
    wire stop_w = scl_sync_r[1] & scl_d_r & ~sda_d_r & sda_sync_r[1];
    wire [9:0] strap_raw_w = {charge_disable_strap_in, addr_strap_in,
        threshold_strap_in, timing_strap_in, ratio_strap_in};

    // pin synchronisers and start/stop detection
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            scl_sync_r <= 2'h3;
            sda_sync_r <= 2'h3;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            strap_s1_r <= 10'h000;
            strap_s2_r <= 10'h000;
            frame_rst_r <= 1'b0;
        end else if (ce_in) begin
            scl_sync_r <= {scl_sync_r[0], scl_in};
            sda_sync_r <= {sda_sync_r[0], sda_in};
            scl_d_r <= scl_sync_r[1];
            sda_d_r <= sda_sync_r[1];
            strap_s1_r <= strap_raw_w;
            strap_s2_r <= strap_s1_r;
            frame_rst_r <= start_w | stop_w;
        end
    end

    // write event handed over from the link side by a toggle
    wire wr_evt_w = wr_tgl_sync_r[1] ^ wr_tgl_d_r;
    wire wr_trk_w = wr_evt_w & (wr_addr_lk_r == `HICS_REG_TRACKING);
    wire wr_ovdis_w = wr_evt_w & (wr_addr_lk_r == `HICS_REG_OVDIS);
    wire wr_ovch_w = wr_evt_w & (wr_addr_lk_r == `HICS_REG_OVCH);
    wire wr_ctrl_w = wr_evt_w & (wr_addr_lk_r == `HICS_REG_CTRL);
    wire ratio_ok_w =
        wr_data_lk_r[`HICS_RATIO_MSB:`HICS_RATIO_LSB] <= `HICS_RATIO_MAX;
    wire [3:0] ratio_wr_w = ratio_ok_w ?
        wr_data_lk_r[`HICS_RATIO_MSB:`HICS_RATIO_LSB] :
        tracking_r[`HICS_RATIO_MSB:`HICS_RATIO_LSB];
    wire [6:0] trk_nxt =
        {wr_data_lk_r[`HICS_TIMING_MSB:`HICS_TIMING_LSB], ratio_wr_w};

    // register file, written only from crossed write events
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            wr_tgl_sync_r <= 2'h0;
            wr_tgl_d_r <= 1'b0;
            tracking_r <= `HICS_RST_TRACKING;
            ovdis_r <= `HICS_RST_OVDIS;
            ovch_r <= `HICS_RST_OVCH;
            use_regs_r <= 1'b0;
        end else if (ce_in) begin
            wr_tgl_sync_r <= {wr_tgl_sync_r[0], wr_tgl_r};
            wr_tgl_d_r <= wr_tgl_sync_r[1];
            if (wr_trk_w) begin
                tracking_r <= trk_nxt;
            end
            if (wr_ovdis_w) begin
                ovdis_r <= wr_data_lk_r[5:0];
            end
            if (wr_ovch_w) begin
                ovch_r <= wr_data_lk_r[5:0];
            end
            if (wr_ctrl_w) begin
                use_regs_r <= wr_data_lk_r[`HICS_CTRL_USE_BIT];
            end
        end
    end

    // strap sampling period ticks
    wire strap_tick_w = strap_cnt_r == STRAP_LAST;
    wire chg_tick_w = chg_cnt_r == CHG_LAST;
    // first capture waits until the strap synchroniser holds pin levels
    wire first_smp_w = first_r == `HICS_FIRST_SMP;
    wire smp_all_w = first_smp_w | strap_tick_w;
    wire smp_chg_w = first_smp_w | chg_tick_w;

    // strap capture after reset release and then periodically
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            first_r <= `HICS_FIRST_WAIT;
            strap_cnt_r <= 32'h0000_0000;
            chg_cnt_r <= 32'h0000_0000;
            ratio_smp_r <= 3'h0;
            timing_smp_r <= 2'h0;
            thr_smp_r <= 3'h0;
            addr_smp_r <= 1'b0;
            chg_smp_r <= 1'b0;
        end else if (ce_in) begin
            first_r <= (first_r == 2'h0) ? 2'h0 : first_r - 2'h1;
            strap_cnt_r <= strap_tick_w ? 32'h0000_0000 : strap_cnt_r + 32'h1;
            chg_cnt_r <= chg_tick_w ? 32'h0000_0000 : chg_cnt_r + 32'h1;
            if (smp_all_w) begin
                ratio_smp_r <= strap_s2_r[2:0];
                timing_smp_r <= strap_s2_r[4:3];
                thr_smp_r <= strap_s2_r[7:5];
                addr_smp_r <= strap_s2_r[8];
            end
            if (smp_chg_w) begin
                chg_smp_r <= strap_s2_r[9];
            end
        end
    end

    // strap interpretation per package
    wire [3:0] strap_ratio_w = SMALL_PKG ?
        {`HICS_SMALL_RATIO_HI, ratio_smp_r[0]} :
        {1'b0, ratio_smp_r};
    wire [2:0] strap_timing_w = SMALL_PKG ? `HICS_SMALL_TIMING :
        {`HICS_PIN_TIMING_HI, timing_smp_r};
    wire [2:0] strap_thr_w = SMALL_PKG ? `HICS_SMALL_THR : thr_smp_r;
    wire addr_bit_w = SMALL_PKG ? 1'b1 : addr_smp_r;

    // register or strap selection
    wire [3:0] eff_ratio_w = use_regs_r ?
        tracking_r[`HICS_RATIO_MSB:`HICS_RATIO_LSB] :
        strap_ratio_w;
    wire [2:0] eff_timing_w = use_regs_r ?
        tracking_r[`HICS_TIMING_MSB:`HICS_TIMING_LSB] : strap_timing_w;

    // threshold arithmetic with minimum clamps
    wire [14:0] ovdis_raw_w =
        15'(ovdis_r) * `HICS_QMV_STEP + `HICS_OVDIS_BASE;
    wire [14:0] ovch_raw_w =
        15'(ovch_r) * `HICS_QMV_STEP + `HICS_OVCH_BASE;
    wire [14:0] ovdis_reg_w = (ovdis_raw_w < `HICS_OVDIS_MIN) ?
        `HICS_OVDIS_MIN : ovdis_raw_w;
    wire [14:0] ovch_reg_w = (ovch_raw_w < `HICS_OVCH_MIN) ?
        `HICS_OVCH_MIN : ovch_raw_w;
    wire [14:0] ovdis_eff_w = use_regs_r ? ovdis_reg_w :
        STRAP_OVDIS_TBL[strap_thr_w * 15 +: 15];
    wire [14:0] ovch_eff_w = use_regs_r ? ovch_reg_w :
        STRAP_OVCH_TBL[strap_thr_w * 15 +: 15];

    // registered configuration outputs
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            ratio_code_out <= 4'h0;
            ratio_pct_out <= 7'h00;
            const_imp_out <= 1'b0;
            timing_code_out <= 3'h0;
            samp_dur_ms_out <= 9'h000;
            samp_per_ms_out <= 15'h0000;
            ovdis_qmv_out <= 15'h0000;
            ovch_qmv_out <= 15'h0000;
            charge_disable_out <= 1'b0;
            port_ready_out <= 1'b0;
        end else if (ce_in) begin
            ratio_code_out <= eff_ratio_w;
            ratio_pct_out <= RATIO_PCT_TBL[eff_ratio_w * 7 +: 7];
            const_imp_out <= eff_ratio_w == 4'h0;
            timing_code_out <= eff_timing_w;
            samp_dur_ms_out <= DUR_MS_TBL[eff_timing_w * 9 +: 9];
            samp_per_ms_out <= PER_MS_TBL[eff_timing_w * 15 +: 15];
            ovdis_qmv_out <= ovdis_eff_w;
            ovch_qmv_out <= ovch_eff_w;
            charge_disable_out <= ~use_regs_r & chg_smp_r;
            port_ready_out <= 1'b1;
        end
    end

    // ---------------- link side, clocked by the serial clock ----------------
    // link logic restarts on reset and on every start or stop
    wire lk_rst_w = rst_in | frame_rst_r;
    wire [7:0] byte_w = {shift_r[6:0], sda_in};
    wire at_last_w = bit_cnt_r == `HICS_BIT_LAST;
    wire at_ack_w = bit_cnt_r == `HICS_BIT_ACK;
    wire addr_hit_w = byte_w[7:1] ==
        (`HICS_SLAVE_ADDR_BASE | {6'h00, addr_lk_r[1]});
    wire is_write_w = byte_w[0] == DIR_WRITE_VALUE;
    wire in_addr_w = state_r == hics_pkg::HICS_ST_ADDR;
    wire in_ptr_w = state_r == hics_pkg::HICS_ST_PTR;
    wire in_wdata_w = state_r == hics_pkg::HICS_ST_WDATA;
    wire in_rdata_w = state_r == hics_pkg::HICS_ST_RDATA;
    wire ack_due_w = (in_addr_w & addr_hit_w) | in_ptr_w | in_wdata_w;
    wire master_ack_w = at_ack_w & in_rdata_w & ~rd_first_r & ~sda_in;
    wire rd_load_w = at_ack_w & in_rdata_w & (rd_first_r | ~sda_in);

    // read pointer and returned word
    wire [7:0] rd_sel_w = master_ack_w ? ptr_r + 8'h01 : ptr_r;
    wire [7:0] status_w = {chg_smp_r, addr_smp_r, thr_smp_r, ratio_smp_r};
    wire [7:0] rd_word_w =
        (rd_sel_w == `HICS_REG_TRACKING) ? {1'b0, tracking_r} :
        (rd_sel_w == `HICS_REG_OVDIS) ? {2'h0, ovdis_r} :
        (rd_sel_w == `HICS_REG_OVCH) ? {2'h0, ovch_r} :
        (rd_sel_w == `HICS_REG_CTRL) ? {7'h00, use_regs_r} :
        (rd_sel_w == `HICS_REG_STATUS) ? status_w : 8'h00;

    // byte phase sequencing at the end of each byte
    always_comb begin
        case (state_r)
            hics_pkg::HICS_ST_ADDR: begin
                if (!addr_hit_w) begin
                    state_nxt = hics_pkg::HICS_ST_IGNORE;
                end else if (is_write_w) begin
                    state_nxt = hics_pkg::HICS_ST_PTR;
                end else begin
                    state_nxt = hics_pkg::HICS_ST_RDATA;
                end
            end
            hics_pkg::HICS_ST_PTR: state_nxt = hics_pkg::HICS_ST_WDATA;
            hics_pkg::HICS_ST_WDATA: state_nxt = hics_pkg::HICS_ST_WDATA;
            hics_pkg::HICS_ST_RDATA: state_nxt = hics_pkg::HICS_ST_RDATA;
            default: state_nxt = hics_pkg::HICS_ST_IGNORE;
        endcase
    end

    // address strap level into the link domain
    always_ff @(posedge scl_in or posedge rst_in) begin
        if (rst_in) begin
            addr_lk_r <= 2'h3;
        end else begin
            addr_lk_r <= {addr_lk_r[0], addr_bit_w};
        end
    end

    // receive shifting, acknowledge decision and read loading
    always_ff @(posedge scl_in or posedge lk_rst_w) begin
        if (lk_rst_w) begin
            state_r <= hics_pkg::HICS_ST_ADDR;
            bit_cnt_r <= 4'h0;
            shift_r <= 8'h00;
            tx_r <= 8'h00;
            ack_r <= 1'b0;
            rd_first_r <= 1'b0;
        end else begin
            bit_cnt_r <= at_ack_w ? 4'h0 : bit_cnt_r + 4'h1;
            shift_r <= byte_w;
            if (at_last_w) begin
                state_r <= state_nxt;
                ack_r <= ack_due_w;
                rd_first_r <= in_addr_w & addr_hit_w & ~is_write_w;
            end else if (at_ack_w) begin
                ack_r <= 1'b0;
                rd_first_r <= 1'b0;
                if (in_rdata_w && !rd_load_w) begin
                    state_r <= hics_pkg::HICS_ST_IGNORE;
                end
            end
            if (rd_load_w) begin
                tx_r <= rd_word_w;
            end else if (in_rdata_w) begin
                tx_r <= {tx_r[6:0], 1'b0};
            end
        end
    end

    // pointer and write hand-off survive repeated starts
    always_ff @(posedge scl_in or posedge rst_in) begin
        if (rst_in) begin
            ptr_r <= 8'h00;
            wr_addr_lk_r <= 8'h00;
            wr_data_lk_r <= 8'h00;
            wr_tgl_r <= 1'b0;
        end else if (at_last_w && in_ptr_w) begin
            ptr_r <= byte_w;
        end else if (at_last_w && in_wdata_w) begin
            ptr_r <= ptr_r + 8'h01;
            wr_addr_lk_r <= ptr_r;
            wr_data_lk_r <= byte_w;
            wr_tgl_r <= ~wr_tgl_r;
        end else if (master_ack_w) begin
            ptr_r <= ptr_r + 8'h01;
        end
    end

    // data line drive changes only while the clock is low
    always_ff @(negedge scl_in or posedge lk_rst_w) begin
        if (lk_rst_w) begin
            sda_oe_r <= 1'b0;
        end else begin
            sda_oe_r <= (at_ack_w & ack_r) |
                (in_rdata_w & ~at_ack_w & ~tx_r[7]);
        end
    end

    assign sda_out = 1'b0; // open drain: only ever pulls low
    assign sda_oe_out = sda_oe_r;

endmodule : hics_config_slave
`default_nettype wire

// ---- hics_config_slave_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module hics_config_slave_sva (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic scl_in,
    input wire logic sda_oe_out,
    input wire logic [3:0] ratio_code_out,
    input wire logic [6:0] ratio_pct_out,
    input wire logic const_imp_out,
    input wire logic [2:0] timing_code_out,
    input wire logic [8:0] samp_dur_ms_out,
    input wire logic [14:0] samp_per_ms_out,
    input wire logic [14:0] ovdis_qmv_out,
    input wire logic [14:0] ovch_qmv_out,
    input wire logic port_ready_out
);
    // system clock checks, quiet while reset is applied
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (rst_in);

    // decoded outputs agree with the effective codes once settled
    a_code_in_range: assert property (
        $past(port_ready_out, 2) |-> ratio_code_out <= 4'h9)
        else $error("ratio code out of range");
    a_imp_pct_zero: assert property (
        $past(port_ready_out, 2) |->
        (ratio_pct_out == 7'h00) == const_imp_out)
        else $error("impedance flag and percent disagree");
    a_imp_from_code: assert property (
        $past(port_ready_out, 2) |->
        const_imp_out == (ratio_code_out == 4'h0))
        else $error("impedance flag does not follow code");
    a_pct_sixty: assert property (
        ratio_code_out == 4'h3 |-> ratio_pct_out == 7'h3c)
        else $error("code 3 not decoded as 60 percent");
    a_pct_half: assert property (
        ratio_code_out == 4'h9 |-> ratio_pct_out == 7'h32)
        else $error("code 9 not decoded as 50 percent");
    a_timing_long: assert property (
        timing_code_out == 3'h1 |->
        samp_dur_ms_out == 9'h100 && samp_per_ms_out == 15'h4000)
        else $error("timing code 1 decoded wrongly");
    a_timing_fast: assert property (
        $past(port_ready_out, 2) && timing_code_out == 3'h0 |->
        samp_dur_ms_out == 9'h002 && samp_per_ms_out == 15'h0040)
        else $error("timing code 0 decoded wrongly");
    // thresholds never fall under their floors
    a_ovdis_floor: assert property (
        $past(port_ready_out, 2) |-> ovdis_qmv_out >= 15'h2bc0)
        else $error("overdischarge threshold below floor");
    a_ovch_floor: assert property (
        $past(port_ready_out, 2) |-> ovch_qmv_out >= 15'h2ee0)
        else $error("overcharge threshold below floor");
    // data line only moves while the serial clock is low
    a_oe_scl_low: assert property (
        $changed(sda_oe_out) |-> !scl_in)
        else $error("data line changed while clock high");
    a_ready_stays: assert property (
        $past(port_ready_out) |-> port_ready_out)
        else $error("port ready dropped");
endmodule : hics_config_slave_sva

bind hics_config_slave hics_config_slave_sva chk_u (
    .clk_sys_in, .rst_in, .scl_in, .sda_oe_out, .ratio_code_out,
    .ratio_pct_out, .const_imp_out, .timing_code_out, .samp_dur_ms_out,
    .samp_per_ms_out, .ovdis_qmv_out, .ovch_qmv_out, .port_ready_out
);
`default_nettype wire

// ---- hics_config_slave_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module hics_config_slave_test;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic [2:0] ratio_strap = 3'h5;
    logic [1:0] timing_strap = 2'h2;
    logic [2:0] thr_strap = 3'h0;
    logic chg_strap = 1'b0;
    logic addr_strap = 1'b0;
    logic scl, m_sda_low, sda_o, sda_oe, const_imp, chg_dis, ready, ack;
    logic [3:0] ratio_code;
    logic [6:0] ratio_pct;
    logic [2:0] timing_code;
    logic [8:0] dur;
    logic [14:0] per, ovdis, ovch;
    wire logic sda_line;
    int n_mismatch = 0;
    int checked = 0;
    logic [7:0] wq[$];
    logic [7:0] rq[$];
    logic [6:0] pct_t[10] = '{7'h00, 7'h5a, 7'h41, 7'h3c, 7'h55, 7'h4b,
        7'h46, 7'h50, 7'h23, 7'h32};
    logic [8:0] dur_t[8] = '{9'h002, 9'h100, 9'h040, 9'h008, 9'h004,
        9'h002, 9'h004, 9'h002};
    logic [14:0] per_t[8] = '{15'h0040, 15'h4000, 15'h1000, 15'h0400,
        15'h0100, 15'h0080, 15'h0200, 15'h0100};
    logic [14:0] sch_t[8] = '{15'h4650, 15'h3e80, 15'h38b8, 15'h3cf0,
        15'h3cf0, 15'h3cf0, 15'h43f8, 15'h4060};
    logic [14:0] sdis_t[8] = '{15'h3390, 15'h2bc0, 15'h2bc0, 15'h2bc0,
        15'h36b0, 15'h2f08, 15'h2f08, 15'h2f08};

    // open-drain data line with pull-up, 200 MHz system clock
    assign sda_line = !(sda_oe || m_sda_low);
    always #2.5 clk_sys = ~clk_sys;

    hics_config_slave #(.STRAP_PERIOD_CYCLES(64), .CHG_PERIOD_CYCLES(32))
    dut_u (.clk_sys_in(clk_sys), .rst_in(rst), .ce_in(1'b1),
        .scl_in(scl), .sda_in(sda_line), .sda_out(sda_o),
        .sda_oe_out(sda_oe), .ratio_strap_in(ratio_strap),
        .timing_strap_in(timing_strap), .threshold_strap_in(thr_strap),
        .addr_strap_in(addr_strap), .charge_disable_strap_in(chg_strap),
        .ratio_code_out(ratio_code), .ratio_pct_out(ratio_pct),
        .const_imp_out(const_imp), .timing_code_out(timing_code),
        .samp_dur_ms_out(dur), .samp_per_ms_out(per),
        .ovdis_qmv_out(ovdis), .ovch_qmv_out(ovch),
        .charge_disable_out(chg_dis), .port_ready_out(ready));

    hics_i2c_master_model mdl_u (.sda_line_in(sda_line), .scl_out(scl),
        .sda_low_out(m_sda_low));

    // compare and count
    task chk(input string what, input logic [15:0] exp,
        input logic [15:0] got);
        checked++;
        if (exp !== got) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task tally_and_finish;
        if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // pointer then every queued byte, each acknowledged
    task reg_write(input logic [7:0] ptr);
        @(negedge clk_sys);
        mdl_u.start_cond();
        mdl_u.send_byte(8'h81, ack);
        chk("addr ack", 16'h1, 16'(ack));
        mdl_u.send_byte(ptr, ack);
        chk("ptr ack", 16'h1, 16'(ack));
        foreach (wq[j]) begin
            mdl_u.send_byte(wq[j], ack);
            chk("data ack", 16'h1, 16'(ack));
        end
        mdl_u.stop_cond();
        repeat (8) @(negedge clk_sys);
    endtask : reg_write

    // pointer write, repeated start, n bytes, refusal on the last
    task reg_read(input logic [7:0] ptr, input int n);
        logic [7:0] b;
        @(negedge clk_sys);
        mdl_u.start_cond();
        mdl_u.send_byte(8'h81, ack);
        mdl_u.send_byte(ptr, ack);
        mdl_u.start_cond();
        mdl_u.send_byte(8'h80, ack);
        chk("read addr ack", 16'h1, 16'(ack));
        rq.delete();
        for (int i = 0; i < n; i++) begin
            mdl_u.recv_byte(i < n - 1, b);
            rq.push_back(b);
        end
        mdl_u.stop_cond();
    endtask : reg_read

    // main sequence
    initial begin
        repeat (6) @(posedge clk_sys);
        @(negedge clk_sys) rst = 1'b0;
        for (int k = 0; k < 100 && ready !== 1'b1; k++) @(negedge clk_sys);
        chk("port_ready", 16'h1, 16'(ready));
        repeat (4) @(negedge clk_sys);
        chk("cold ratio", 16'h5, 16'(ratio_code));
        chk("cold ovch", 16'h4650, 16'(ovch));
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_sys);
            ratio_strap = 3'(i);
            timing_strap = 2'(i);
            thr_strap = 3'(i);
            chg_strap = i[0];
            repeat (200) @(negedge clk_sys);
            chk("strap ratio", 16'(i), 16'(ratio_code));
            chk("strap pct", 16'(pct_t[i]), 16'(ratio_pct));
            chk("strap timing", 16'(i % 4 + 4), 16'(timing_code));
            chk("strap ovch", 16'(sch_t[i]), 16'(ovch));
            chk("strap ovdis", 16'(sdis_t[i]), 16'(ovdis));
            chk("strap chg", 16'(i % 2), 16'(chg_dis));
        end
        @(negedge clk_sys);
        mdl_u.start_cond();
        mdl_u.send_byte(8'h83, ack);
        chk("foreign addr ack", 16'h0, 16'(ack));
        mdl_u.stop_cond();
        @(negedge clk_sys) addr_strap = 1'b1;
        repeat (200) @(negedge clk_sys);
        mdl_u.start_cond();
        mdl_u.send_byte(8'h83, ack);
        chk("strap addr ack", 16'h1, 16'(ack));
        chk("sda level", 16'h0, 16'(sda_o));
        mdl_u.stop_cond();
        @(negedge clk_sys) addr_strap = 1'b0;
        repeat (200) @(negedge clk_sys);
        wq = '{8'hc5, 8'he8, 8'h20, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
        reg_write(8'h01);
        chk("ratio", 16'h5, 16'(ratio_code));
        chk("timing", 16'h4, 16'(timing_code));
        chk("dur", 16'h4, 16'(dur));
        chk("ovdis clamp", 16'h2bc0, 16'(ovdis));
        chk("ovch", 16'h2f76, 16'(ovch));
        chk("chg off", 16'h0, 16'(chg_dis));
        reg_read(8'h01, 3);
        chk("rd tracking", 16'h45, 16'(rq[0]));
        chk("rd ovdis", 16'h28, 16'(rq[1]));
        chk("rd ovch", 16'h20, 16'(rq[2]));
        reg_read(8'h05, 1);
        chk("rd unmapped", 16'h0, 16'(rq[0]));
        wq = '{8'h29, 8'h1f};
        reg_write(8'h02);
        chk("ovdis edge", 16'h2bf2, 16'(ovdis));
        chk("ovch clamp", 16'h2ee0, 16'(ovch));
        for (int i = 0; i < 10; i++) begin
            wq = '{{1'b0, 3'(i), 4'(i)}};
            reg_write(8'h01);
            chk("ratio", 16'(i), 16'(ratio_code));
            chk("pct", 16'(pct_t[i]), 16'(ratio_pct));
            chk("imp", 16'(i == 0), 16'(const_imp));
            chk("dur", 16'(dur_t[i % 8]), 16'(dur));
            chk("per", 16'(per_t[i % 8]), 16'(per));
        end
        @(negedge clk_sys) thr_strap = 3'h0;
        repeat (200) @(negedge clk_sys);
        chk("strap ignored", 16'h2ee0, 16'(ovch));
        wq = '{8'h00};
        reg_write(8'h08);
        repeat (200) @(negedge clk_sys);
        chk("strap ovch back", 16'h4650, 16'(ovch));
        chk("strap ovdis back", 16'h3390, 16'(ovdis));
        tally_and_finish();
    end

    // hang guard
    initial begin
        #300000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule : hics_config_slave_test
`default_nettype wire

// ---- hics_consts.svh ----
`ifndef HICS_CONSTS_SVH
`define HICS_CONSTS_SVH

// register pointers
`define HICS_REG_TRACKING 8'h01
`define HICS_REG_OVDIS 8'h02
`define HICS_REG_OVCH 8'h03
`define HICS_REG_CTRL 8'h08
`define HICS_REG_STATUS 8'h09

// reset values
`define HICS_RST_TRACKING 7'h00
`define HICS_RST_OVDIS 6'h00
`define HICS_RST_OVCH 6'h00

// field positions
`define HICS_RATIO_MSB 3
`define HICS_RATIO_LSB 0
`define HICS_TIMING_MSB 6
`define HICS_TIMING_LSB 4
`define HICS_CTRL_USE_BIT 0
`define HICS_RATIO_MAX 4'h9

// serial framing
`define HICS_SLAVE_ADDR_BASE 7'h40
`define HICS_BIT_LAST 4'h7
`define HICS_BIT_ACK 4'h8

// timing: system clock rate and strap sampling periods
`define HICS_CLK_KHZ 200000
`define HICS_STRAP_PERIOD_MS 2000
`define HICS_CHG_PERIOD_MS 1000
`define HICS_FIRST_WAIT 2'h3
`define HICS_FIRST_SMP 2'h1

// threshold arithmetic in quarter millivolts
`define HICS_QMV_STEP 15'h00e1
`define HICS_OVDIS_BASE 15'h07e9
`define HICS_OVCH_BASE 15'h1356
`define HICS_OVDIS_MIN 15'h2bc0
`define HICS_OVCH_MIN 15'h2ee0

// codes forced on each package
`define HICS_SMALL_RATIO_HI 3'h3
`define HICS_SMALL_TIMING 3'h7
`define HICS_SMALL_THR 3'h7
`define HICS_PIN_TIMING_HI 1'h1

// lookup tables, entry 0 in the low bits
`define HICS_RATIO_PCT_TBL {7'h32, 7'h23, 7'h50, 7'h46, 7'h4b, 7'h55, \
    7'h3c, 7'h41, 7'h5a, 7'h00}
`define HICS_DUR_MS_TBL {9'h002, 9'h004, 9'h002, 9'h004, 9'h008, 9'h040, \
    9'h100, 9'h002}
`define HICS_PER_MS_TBL {15'h0100, 15'h0200, 15'h0080, 15'h0100, \
    15'h0400, 15'h1000, 15'h4000, 15'h0040}
`define HICS_STRAP_OVCH_TBL {15'h4060, 15'h43f8, 15'h3cf0, 15'h3cf0, \
    15'h3cf0, 15'h38b8, 15'h3e80, 15'h4650}
`define HICS_STRAP_OVDIS_TBL {15'h2f08, 15'h2f08, 15'h2f08, 15'h36b0, \
    15'h2bc0, 15'h2bc0, 15'h2bc0, 15'h3390}

`endif

// ---- hics_i2c_master_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module hics_i2c_master_model (
    input wire logic sda_line_in,
    output logic scl_out,
    output logic sda_low_out
);
    // clock parked high and data released between frames
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end

    // start or repeated start, long setup for the sync stage
    task start_cond;
        sda_low_out = 1'b0;
        #16 scl_out = 1'b1;
        #24 sda_low_out = 1'b1;
        #48 scl_out = 1'b0;
    endtask : start_cond

    // stop leaves the bus idle
    task stop_cond;
        sda_low_out = 1'b1;
        #16 scl_out = 1'b1;
        #24 sda_low_out = 1'b0;
        #48;
    endtask : stop_cond

    // one 32 ns clock, data set while low, sampled at rise
    task clock_bit(input logic b, output logic s);
        sda_low_out = !b;
        #16 scl_out = 1'b1;
        s = sda_line_in;
        #16 scl_out = 1'b0;
    endtask : clock_bit

    // byte out, then the slave's acknowledge slot
    task send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(b[i], s);
        end
        clock_bit(1'b1, s);
        ack = !s;
    endtask : send_byte

    // byte in, then our own acknowledge or refusal
    task recv_byte(input logic ack_it, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(1'b1, b[i]);
        end
        clock_bit(!ack_it, s);
    endtask : recv_byte
endmodule : hics_i2c_master_model
`default_nettype wire

// ---- hics_pkg.sv ----
`default_nettype none
package hics_pkg;

    // link-side byte phases
    typedef enum logic [2:0] {
        HICS_ST_ADDR,
        HICS_ST_PTR,
        HICS_ST_WDATA,
        HICS_ST_RDATA,
        HICS_ST_IGNORE
    } hics_lk_state_t;

endpackage : hics_pkg
`default_nettype wire
